/* hdl/rsq_pkg.sv */
package rsq_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] CAUSE_OFS   = 4'h0;
  localparam logic [3:0] CTRL_OFS    = 4'h4;
  localparam logic [3:0] IRQ_ST_OFS  = 4'h8;
  localparam logic [3:0] IRQ_MSK_OFS = 4'hC;
  // cause flag positions
  localparam int POR_BIT = 0;
  localparam int EXT_BIT = 1;
  localparam int BOR_BIT = 2;
  localparam int WDT_BIT = 3;
  localparam int DBG_BIT = 4;
  localparam int SW_BIT  = 5;
  localparam int NSRC    = 6;
  // control register fields
  localparam int SWRST_BIT = 0;
  localparam int BOOTV_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // startup delay codes
  localparam logic [1:0] SUT_64K  = 2'h0;
  localparam logic [1:0] SUT_4K   = 2'h1;
  localparam logic [1:0] SUT_RSVD = 2'h2;
  localparam logic [1:0] SUT_NONE = 2'h3;
  localparam logic [16:0] SLOW_64K = 17'h10000;
  localparam logic [16:0] SLOW_4K  = 17'h01000;
  localparam logic [4:0]  SYS_CYC  = 5'h18;
  localparam logic [1:0]  BRESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // sequencer states
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_SLOW = 5'h02,
    ST_SYS  = 5'h04,
    ST_OSC  = 5'h08,
    ST_RUN  = 5'h10
  } rsq_state_t;
endpackage

/* hdl/rsq_sequencer.sv */
`timescale 1ns/1ps
// Operation
// - any request enters reset on the next clock edge; held until all requests withdraw
// - I/O pins tri-stated on the same clock edge as reset entry
// - reset loads PC with reset vector and I/O registers with defaults
// - SRAM contents are left untouched by reset
// - reset vector is 0 unless relocated to boot section start
// - after release: delay counter, oscillator start, calibration, then run
// - a new request during the post-release stages restarts the sequence
// - delay counts slow oscillator cycles then 24 system cycles
// - fuse 00 is 64K, 01 is 4K, 11 is 24 system cycles only
// - every reset returns clocks to reset state with 2MHz oscillator
// - after delay start 2MHz oscillator and load its calibration row
// - reset entry is registered and needs an edge of the system clock
// - six sources: power-on, pin, watchdog, brownout, debug, software
// - software triggers full system reset by a register write
// - one cause flag per source; power-on reset clears all but its own, which it sets
// - software reset takes effect within two clocks of the write
// - writing one to a cause flag clears it
module rsq_sequencer #(
  parameter logic [15:0] BOOT_VECTOR = 16'h0100,
  parameter int          CAL_W       = 8
) (
  // clock and power-on reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset,
  // reset requests
  input  wire logic                    i_ext_req,
  input  wire logic                    i_wdt_req,
  input  wire logic                    i_bod_req,
  input  wire logic                    i_dbg_req,
  // slow timing oscillator tick and fuses
  input  wire logic                    i_slow_tick,
  input  wire logic [1:0]              i_startup_delay_fuse,
  input  wire logic                    i_osc_ready,
  input  wire logic [CAL_W-1:0]        i_cal_row,
  // outputs to the core
  output logic                         o_sys_reset,
  output logic                         o_io_tristate,
  output logic [15:0]                  o_reset_vector,
  output logic                         o_osc_enable,
  output logic                         o_clk_sel_2m,
  output logic                         o_cal_load,
  output logic [CAL_W-1:0]             o_cal_value,
  output logic                         o_irq,
  // AXI4-Lite slave
  input  wire logic [3:0]              i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output logic [1:0]                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  input  wire logic [3:0]              i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output logic [1:0]                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready
);

  rsq_pkg::rsq_state_t         state_reg;
  logic [16:0]                 slow_cnt_reg;
  logic [4:0]                  sys_cnt_reg;
  logic [7:0]                  ctrl_reg;
  logic [rsq_pkg::NSRC-1:0]    cause_reg;
  logic [rsq_pkg::NSRC-1:0]    irq_st_reg;
  logic [rsq_pkg::NSRC-1:0]    irq_msk_reg;
  logic                        sw_req_reg;
  logic                        aw_hold_reg;
  logic                        w_hold_reg;
  logic [3:0]                  awaddr_reg;
  logic [31:0]                 wdata_reg;
  logic [3:0]                  wstrb_reg;
  logic [rsq_pkg::NSRC-1:0]    src_req;
  logic                        any_req;
  logic                        do_write;
  logic                        do_read;
  logic [3:0]                  wr_addr;
  logic [31:0]                 wr_data;
  logic                        wr_lane0;
  logic [31:0]                 rd_data;
  logic                        rd_ok;
  logic [16:0]                 slow_target;

  // gather all six requests; power-on is i_reset itself
  assign src_req[rsq_pkg::POR_BIT] = i_reset;
  assign src_req[rsq_pkg::EXT_BIT] = i_ext_req;
  assign src_req[rsq_pkg::BOR_BIT] = i_bod_req;
  assign src_req[rsq_pkg::WDT_BIT] = i_wdt_req;
  assign src_req[rsq_pkg::DBG_BIT] = i_dbg_req;
  assign src_req[rsq_pkg::SW_BIT]  = sw_req_reg;
  assign any_req = |src_req;

  // write address and data may come in either order
  assign wr_addr  = aw_hold_reg ? awaddr_reg : i_awaddr;
  assign wr_data  = w_hold_reg ? wdata_reg : i_wdata;
  assign wr_lane0 = w_hold_reg ? wstrb_reg[0] : i_wstrb[0];
  // a channel only counts once its own handshake has happened, otherwise
  // a held valid would be taken twice while its ready is low
  assign do_write = (aw_hold_reg | (i_awvalid & o_awready)) &
                    (w_hold_reg | (i_wvalid & o_wready)) & ~o_bvalid;
  assign do_read  = i_arvalid & o_arready;

  // fuse decode; reserved code falls to the shortest delay
  always_comb begin
    case (i_startup_delay_fuse)
      rsq_pkg::SUT_64K: slow_target = rsq_pkg::SLOW_64K;
      rsq_pkg::SUT_4K:  slow_target = rsq_pkg::SLOW_4K;
      default:          slow_target = 17'h00000;
    endcase
  end

  // sequencer: release stages restart on any request
  always_ff @(posedge i_sys_clk) begin
    if (any_req) begin
      state_reg <= rsq_pkg::ST_HOLD;
    end else begin
      case (state_reg)
        rsq_pkg::ST_HOLD: state_reg <= (slow_target == 17'h00000) ?
                                       rsq_pkg::ST_SYS : rsq_pkg::ST_SLOW;
        rsq_pkg::ST_SLOW: if (slow_cnt_reg == slow_target) begin
                            state_reg <= rsq_pkg::ST_SYS;
                          end
        rsq_pkg::ST_SYS:  if (sys_cnt_reg == rsq_pkg::SYS_CYC) begin
                            state_reg <= rsq_pkg::ST_OSC;
                          end
        rsq_pkg::ST_OSC:  if (i_osc_ready) begin
                            state_reg <= rsq_pkg::ST_RUN;
                          end
        default:          state_reg <= rsq_pkg::ST_RUN;
      endcase
    end
  end

  // delay counters; the slow one advances only on oscillator ticks
  always_ff @(posedge i_sys_clk) begin
    if (any_req || state_reg == rsq_pkg::ST_HOLD) begin
      slow_cnt_reg <= 17'h00000;
      sys_cnt_reg  <= 5'h00;
    end else begin
      if (state_reg == rsq_pkg::ST_SLOW && i_slow_tick) begin
        slow_cnt_reg <= slow_cnt_reg + 17'h00001;
      end
      if (state_reg == rsq_pkg::ST_SYS) begin
        sys_cnt_reg <= sys_cnt_reg + 5'h01;
      end
    end
  end

  // core-facing outputs; entry is combinational from the request set
  // but registered here for clean outputs, release lands on one edge
  always_ff @(posedge i_sys_clk) begin
    o_sys_reset    <= any_req | (state_reg != rsq_pkg::ST_RUN);
    o_io_tristate  <= any_req | (state_reg != rsq_pkg::ST_RUN);
    o_clk_sel_2m   <= any_req | o_clk_sel_2m;
    o_osc_enable   <= ~any_req & ((state_reg == rsq_pkg::ST_OSC) |
                      (state_reg == rsq_pkg::ST_RUN));
    o_cal_load     <= ~any_req & (state_reg == rsq_pkg::ST_OSC) &
                      i_osc_ready;
    o_reset_vector <= ctrl_reg[rsq_pkg::BOOTV_BIT] ? BOOT_VECTOR :
                      16'h0000;
    if (i_reset) begin
      o_cal_value <= '0;
    end else if (state_reg == rsq_pkg::ST_OSC && i_osc_ready) begin
      o_cal_value <= i_cal_row;
    end
  end

  // control register; survives other resets, only power-on clears it.
  // the reset bit self-clears once the request is registered
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_reg   <= rsq_pkg::CTRL_RST;
      sw_req_reg <= 1'b0;
    end else begin
      sw_req_reg <= 1'b0;
      if (do_write && wr_addr == rsq_pkg::CTRL_OFS && wr_lane0) begin
        ctrl_reg   <= wr_data[7:0] & 8'h02;
        sw_req_reg <= wr_data[rsq_pkg::SWRST_BIT];
      end
    end
  end

  // cause flags and interrupt status; set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cause_reg  <= 6'h01;
      irq_st_reg <= 6'h01;
    end else begin
      for (int i = 0; i < rsq_pkg::NSRC; i++) begin
        if (src_req[i]) begin
          cause_reg[i]  <= 1'b1;
          irq_st_reg[i] <= 1'b1;
        end else begin
          if (do_write && wr_addr == rsq_pkg::CAUSE_OFS && wr_lane0 &&
              wr_data[i]) begin
            cause_reg[i] <= 1'b0;
          end
          if (do_read && i_araddr == rsq_pkg::IRQ_ST_OFS) begin
            irq_st_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // interrupt mask and level output
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_msk_reg <= 6'h00;
      o_irq       <= 1'b0;
    end else begin
      if (do_write && wr_addr == rsq_pkg::IRQ_MSK_OFS && wr_lane0) begin
        irq_msk_reg <= wr_data[5:0];
      end
      o_irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // write channel capture and response
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      o_bvalid    <= 1'b0;
      o_bresp     <= rsq_pkg::BRESP_OK;
    end else begin
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        o_bvalid    <= 1'b1;
        o_bresp     <= (wr_addr == rsq_pkg::CAUSE_OFS ||
                        wr_addr == rsq_pkg::CTRL_OFS ||
                        wr_addr == rsq_pkg::IRQ_MSK_OFS ||
                        wr_addr == rsq_pkg::IRQ_ST_OFS) ?
                       rsq_pkg::BRESP_OK : rsq_pkg::RESP_ERR;
      end else begin
        if (i_awvalid && o_awready) begin
          aw_hold_reg <= 1'b1;
          awaddr_reg  <= i_awaddr;
        end
        if (i_wvalid && o_wready) begin
          w_hold_reg <= 1'b1;
          wdata_reg  <= i_wdata;
          wstrb_reg  <= i_wstrb;
        end
        if (o_bvalid && i_bready) begin
          o_bvalid <= 1'b0;
        end
      end
    end
  end

  // ready flags registered; idle slots accept
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_arready <= 1'b0;
    end else begin
      o_awready <= ~aw_hold_reg & ~do_write & ~o_bvalid &
                   ~(i_awvalid & o_awready);
      o_wready  <= ~w_hold_reg & ~do_write & ~o_bvalid &
                   ~(i_wvalid & o_wready);
      o_arready <= ~o_rvalid & ~do_read;
    end
  end

  // read decode
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h00000000;
    if (i_araddr == rsq_pkg::CAUSE_OFS) begin
      rd_data[5:0] = cause_reg;
    end else if (i_araddr == rsq_pkg::CTRL_OFS) begin
      rd_data[7:0] = ctrl_reg;
    end else if (i_araddr == rsq_pkg::IRQ_ST_OFS) begin
      rd_data[5:0] = irq_st_reg;
    end else if (i_araddr == rsq_pkg::IRQ_MSK_OFS) begin
      rd_data[5:0] = irq_msk_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read response
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= rsq_pkg::BRESP_OK;
    end else if (do_read) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_data;
      o_rresp  <= rd_ok ? rsq_pkg::BRESP_OK : rsq_pkg::RESP_ERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // sram sits outside this block and is never touched here
  // entry needs a single edge of the system clock a fully
  // clockless path would have to live in the pad ring

  chk_req_holds: assert property (@(posedge i_sys_clk)
    any_req |=> o_sys_reset) else $error("reset not entered");
  chk_pin_tristate: assert property (@(posedge i_sys_clk)
    any_req |=> o_io_tristate) else $error("pins not tristated");
  chk_restart_seq: assert property (@(posedge i_sys_clk)
    (state_reg != rsq_pkg::ST_HOLD && any_req) |=>
    state_reg == rsq_pkg::ST_HOLD) else $error("no restart");
  chk_sys_24: assert property (@(posedge i_sys_clk) disable iff (any_req)
    (state_reg == rsq_pkg::ST_SYS && sys_cnt_reg == 5'h00) |->
    ##24 state_reg == rsq_pkg::ST_SYS ##1 state_reg == rsq_pkg::ST_OSC)
    else $error("system cycle count wrong");
  chk_swrst_fast: assert property (@(posedge i_sys_clk)
    (do_write && wr_addr == rsq_pkg::CTRL_OFS && wr_lane0 && wr_data[0] &&
     !i_reset) |-> ##[1:2] o_sys_reset) else $error("slow sw reset");
  chk_cause_set: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    i_wdt_req |=> cause_reg[rsq_pkg::WDT_BIT]) else $error("flag lost");
  chk_osc_order: assert property (@(posedge i_sys_clk)
    $rose(o_osc_enable) |-> $past(state_reg) == rsq_pkg::ST_OSC ||
    $past(state_reg) == rsq_pkg::ST_RUN) else $error("osc too early");
  chk_rsvd_short: assert property (@(posedge i_sys_clk)
    (state_reg == rsq_pkg::ST_HOLD && !any_req &&
     i_startup_delay_fuse == rsq_pkg::SUT_RSVD) |=>
    state_reg == rsq_pkg::ST_SYS) else $error("reserved code stalls");

  cov_run: cover property (@(posedge i_sys_clk)
    $fell(o_sys_reset));
  cov_swrst: cover property (@(posedge i_sys_clk)
    $rose(sw_req_reg));
  cov_restart: cover property (@(posedge i_sys_clk)
    state_reg == rsq_pkg::ST_SYS && any_req);

endmodule

/* bench/rsq_far_side.sv */
`timescale 1ns/1ps
module rsq_far_side (
  // clock and oscillator control
  input  wire logic       i_sys_clk,
  input  wire logic       i_osc_enable,
  // slow tick, oscillator ready, calibration row
  output logic            o_slow_tick,
  output logic            o_osc_ready,
  output logic [7:0]      o_cal_row
);
  logic [2:0] lag_reg;

  // slow oscillator sped up to one tick a cycle so the long code fits the run
  assign o_slow_tick = 1'b1;
  // ready lags enable by three cycles and drops with it, like a real start
  always @(posedge i_sys_clk) begin
    lag_reg <= i_osc_enable ? {lag_reg[1:0], 1'b1} : 3'h0;
  end
  assign o_osc_ready = lag_reg[2];
  assign o_cal_row   = 8'hA5; // arbitrary trim pattern
endmodule

/* bench/system_reset_sequencer_tb.sv */
`timescale 1ns/1ps
module system_reset_sequencer_tb;
  logic        clk, rst, tick, ordy, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  req, awaddr, araddr;
  logic [1:0]  fuse, resp;
  logic [31:0] wdata, rdat;
  logic [7:0]  cal;
  logic        sys_rst, tri_s, osc_en, sel2m, cal_ld, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [15:0] vec;
  logic [7:0]  cal_v;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          check_count, fail_count, cyc;
  int          cb[4] = '{rsq_pkg::EXT_BIT, rsq_pkg::WDT_BIT,
                         rsq_pkg::BOR_BIT, rsq_pkg::DBG_BIT};
  int          slow[3] = '{65536, 4096, 0};

  rsq_sequencer dut_u (
    .i_sys_clk(clk), .i_reset(rst), .i_ext_req(req[0]), .i_wdt_req(req[1]),
    .i_bod_req(req[2]), .i_dbg_req(req[3]), .i_slow_tick(tick),
    .i_startup_delay_fuse(fuse), .i_osc_ready(ordy), .i_cal_row(cal),
    .o_sys_reset(sys_rst), .o_io_tristate(tri_s), .o_reset_vector(vec),
    .o_osc_enable(osc_en), .o_clk_sel_2m(sel2m), .o_cal_load(cal_ld),
    .o_cal_value(cal_v), .o_irq(irq), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  rsq_far_side far_u (.i_sys_clk(clk), .i_osc_enable(osc_en),
    .o_slow_tick(tick), .o_osc_ready(ordy), .o_cal_row(cal));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // handshakes sampled at the falling edge, where they equal the rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end while (!bh);
  endtask
  task automatic rd(input logic [3:0] a);
    logic ah, rh;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid && arready; rh = rvalid && rready;
      rdat = rdata; resp = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end while (!rh);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask
  task automatic wait_run;
    do @(posedge clk); while (sys_rst !== 1'b0);
  endtask
  // request held three edges; an optional second request lands mid count
  task automatic run_rst(input int s, input logic [1:0] f, input int sl,
                         input bit again);
    int n;
    logic cl;
    @(posedge clk);
    fuse <= f; req[s] <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(sys_rst, 1);
    chk(tri_s, 1);
    @(posedge clk);
    req[s] <= 1'b0;
    if (again) begin
      repeat (20) @(posedge clk);
      req[s] <= 1'b1;
      @(posedge clk);
      req[s] <= 1'b0;
    end
    n = 0;
    cl = 1'b0;
    do begin
      @(posedge clk);
      #1 n++;
      cl |= cal_ld;
    end while (sys_rst === 1'b1 && n < 70000);
    chk(n >= sl + 24 && n <= sl + 40, 1);
    chk(cl, 1);
    chk(cal_v, 8'hA5);
    chk(sel2m, 1);
    chk(tri_s, 0);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard well above the longest delay code
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 90000) begin
        fail_count++;
        print_verdict;
      end
    end
  end

  initial begin
    rst = 1'b1; req = 4'h0; fuse = rsq_pkg::SUT_NONE; awaddr = 4'h0;
    araddr = 4'h0; wdata = 32'h0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    check_count = 0; fail_count = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_run;
    rchk(rsq_pkg::CAUSE_OFS, 32'h1);
    rchk(rsq_pkg::CTRL_OFS, 32'h0);
    rchk(rsq_pkg::IRQ_MSK_OFS, 32'h0);
    #1 chk(vec, 16'h0000);
    chk(irq, 0);
    wr(rsq_pkg::IRQ_MSK_OFS, 32'h3F);
    chk(resp, rsq_pkg::BRESP_OK);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1);
    rchk(rsq_pkg::IRQ_ST_OFS, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    wr(rsq_pkg::CAUSE_OFS, 32'h1);
    rchk(rsq_pkg::CAUSE_OFS, 32'h0);
    rd(4'h2);
    chk(resp, rsq_pkg::RESP_ERR);
    chk(rdat, 32'h0);
    wr(4'h2, 32'h0);
    chk(resp, rsq_pkg::RESP_ERR);
    for (int s = 0; s < 4; s++) begin
      run_rst(s, rsq_pkg::SUT_NONE, 0, s == 1);
      wait_run;
      rchk(rsq_pkg::CAUSE_OFS, 32'h1 << cb[s]);
      #1 chk(irq, 1);
      rchk(rsq_pkg::IRQ_ST_OFS, 32'h1 << cb[s]);
      wr(rsq_pkg::CAUSE_OFS, 32'h1 << cb[s]);
      rchk(rsq_pkg::CAUSE_OFS, 32'h0);
    end
    for (int f = 0; f < 3; f++) run_rst(0, f[1:0], slow[f], 0);
    wait_run;
    wr(rsq_pkg::CAUSE_OFS, 32'h3F);
    wr(rsq_pkg::CTRL_OFS, 32'h1 << rsq_pkg::SWRST_BIT);
    #1 chk(sys_rst, 1);
    wait_run;
    rchk(rsq_pkg::CAUSE_OFS, 32'h1 << rsq_pkg::SW_BIT);
    rchk(rsq_pkg::CTRL_OFS, 32'h0);
    wr(rsq_pkg::CTRL_OFS, 32'h1 << rsq_pkg::BOOTV_BIT);
    repeat (2) @(posedge clk);
    #1 chk(vec, 16'h0100);
    print_verdict;
  end
endmodule
